// ### usb_endpoint_config.sv
// Implementation choice: the Avalon-MM slave port.
module usb_endpoint_config (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Avalon-MM slave
    input wire logic [17:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Packet capture strobes
    input wire logic sof_done,
    input wire logic [10:0] sof_frame,
    input wire logic setup_done,
    input wire logic [63:0] setup_data,
    input wire logic addr_load,
    input wire logic [6:0] addr_value,
    // Token decoder
    input wire usb_cfg_pkg::token_t token,
    output usb_cfg_pkg::reply_t reply,
    // Steering outputs
    output usb_cfg_pkg::cfg_t cfg
);
    typedef struct packed {
        logic [10:0] frame;
        logic [6:0] dev_addr;
        logic [63:0] setup;
        usb_cfg_pkg::cfg_t cfg;
        logic [31:0] rdata;
        logic ack;
        usb_cfg_pkg::reply_t reply;
    } state_t;

    state_t st_ff;
    state_t nxt_st;
    logic [15:0] idx;
    logic hit;
    logic [7:0] rbyte;

    function automatic logic ep_active(input logic [7:0] r,
                                       input logic [3:0] ep);
        ep_active = (ep == usb_cfg_pkg::ep_zero) ? 1'b1 : r[ep[2:0]];
    endfunction

    function automatic logic [7:0] merge(input logic [7:0] old,
                                         input logic [7:0] wd,
                                         input logic [7:0] keep,
                                         input logic [7:0] fixed);
        merge = (wd & keep) | fixed;
    endfunction

    assign idx = address[17:2];

    always_comb begin
        hit = 1'b1;
        rbyte = usb_cfg_pkg::reg_reset;
        unique case (idx)
            usb_cfg_pkg::idx_frame_low: rbyte = st_ff.frame[7:0];
            usb_cfg_pkg::idx_frame_high:
                rbyte = {5'h00, st_ff.frame[10:8]};
            usb_cfg_pkg::idx_dev_addr: rbyte = {1'b0, st_ff.dev_addr};
            usb_cfg_pkg::idx_pairing: rbyte = st_ff.cfg.pairing;
            usb_cfg_pkg::idx_bulk_in: rbyte = st_ff.cfg.bulk_in;
            usb_cfg_pkg::idx_bulk_out: rbyte = st_ff.cfg.bulk_out;
            usb_cfg_pkg::idx_iso_in: rbyte = st_ff.cfg.iso_in;
            usb_cfg_pkg::idx_iso_out: rbyte = st_ff.cfg.iso_out;
            usb_cfg_pkg::idx_iso_rx_base: rbyte = st_ff.cfg.iso_rx_base;
            usb_cfg_pkg::idx_iso_tx_base: rbyte = st_ff.cfg.iso_tx_base;
            default: begin
                if (idx[15:3] == usb_cfg_pkg::idx_setup_base[15:3]) begin
                    rbyte = st_ff.setup[idx[2:0]*8 +: 8];
                end else begin
                    hit = 1'b0;
                end
            end
        endcase
    end

    always_comb begin
        logic wr;
        logic match;
        logic act;
        wr = 1'b0;
        match = 1'b0;
        act = 1'b0;
        nxt_st = st_ff;
        // Bus: one wait cycle, then answer
        nxt_st.ack = (read | write) & ~st_ff.ack;
        // Write lands at the edge where waitrequest is seen low
        wr = write & st_ff.ack & byteenable[0];
        if (read & ~st_ff.ack) begin
            nxt_st.rdata = {24'h000000, rbyte};
        end
        if (wr && hit) begin
            unique case (idx)
                usb_cfg_pkg::idx_pairing: nxt_st.cfg.pairing = merge(
                    st_ff.cfg.pairing, writedata[7:0],
                    usb_cfg_pkg::pair_mask, 8'h00);
                usb_cfg_pkg::idx_bulk_in: nxt_st.cfg.bulk_in = merge(
                    st_ff.cfg.bulk_in, writedata[7:0],
                    usb_cfg_pkg::bulk_mask,
                    usb_cfg_pkg::bulk_fixed);
                usb_cfg_pkg::idx_bulk_out: nxt_st.cfg.bulk_out = merge(
                    st_ff.cfg.bulk_out, writedata[7:0],
                    usb_cfg_pkg::bulk_mask,
                    usb_cfg_pkg::bulk_fixed);
                usb_cfg_pkg::idx_iso_in: nxt_st.cfg.iso_in = merge(
                    st_ff.cfg.iso_in, writedata[7:0],
                    usb_cfg_pkg::iso_act_mask, 8'h00);
                usb_cfg_pkg::idx_iso_out: nxt_st.cfg.iso_out = merge(
                    st_ff.cfg.iso_out, writedata[7:0],
                    usb_cfg_pkg::iso_act_mask, 8'h00);
                usb_cfg_pkg::idx_iso_rx_base: nxt_st.cfg.iso_rx_base = merge(
                    st_ff.cfg.iso_rx_base, writedata[7:0],
                    usb_cfg_pkg::base_mask, 8'h00);
                usb_cfg_pkg::idx_iso_tx_base: nxt_st.cfg.iso_tx_base = merge(
                    st_ff.cfg.iso_tx_base, writedata[7:0],
                    usb_cfg_pkg::base_mask, 8'h00);
                default: ;
            endcase
        end
        // Whole-packet capture only
        if (sof_done) begin
            nxt_st.frame = (sof_frame > usb_cfg_pkg::frame_max) ?
                usb_cfg_pkg::frame_zero : sof_frame;
        end
        if (setup_done) begin
            nxt_st.setup = setup_data;
        end
        if (addr_load) begin
            nxt_st.dev_addr = addr_value;
        end
        // Token filter
        match = token.addr == st_ff.dev_addr;
        if (token.endp == usb_cfg_pkg::iso_ep) begin
            act = (token.kind == usb_cfg_pkg::pid_in) ?
                st_ff.cfg.iso_in[0] : st_ff.cfg.iso_out[0];
        end else if (token.kind == usb_cfg_pkg::pid_in) begin
            act = ep_active(st_ff.cfg.bulk_in, token.endp);
        end else begin
            act = ep_active(st_ff.cfg.bulk_out, token.endp);
        end
        nxt_st.reply.respond = token.valid & match & act;
        nxt_st.reply.zero_len = 1'b0;
        if (token.valid && match && act &&
            token.endp == usb_cfg_pkg::iso_ep &&
            token.kind == usb_cfg_pkg::pid_in && token.buf_empty) begin
            nxt_st.reply.respond = st_ff.cfg.pairing[usb_cfg_pkg::zlp_bit];
            nxt_st.reply.zero_len =
                st_ff.cfg.pairing[usb_cfg_pkg::zlp_bit];
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            st_ff <= '0;
            st_ff.cfg.bulk_in <= usb_cfg_pkg::bulk_fixed;
            st_ff.cfg.bulk_out <= usb_cfg_pkg::bulk_fixed;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign readdata = st_ff.rdata;
    assign waitrequest = ~st_ff.ack;
    assign reply = st_ff.reply;
    assign cfg = st_ff.cfg;

    a_ack_after_req: assert property (
        @(posedge clock) disable iff (!nrst)
        (read | write) && waitrequest |=> !waitrequest)
        else $error("bus request not answered in one cycle");
    a_ack_one_cycle: assert property (
        @(posedge clock) disable iff (!nrst)
        !waitrequest |=> waitrequest)
        else $error("bus answer held too long");
    a_ack_no_request: assert property (
        @(posedge clock) disable iff (!nrst)
        !read && !write && waitrequest |=> waitrequest)
        else $error("bus answer without request");
    a_read_upper_zero: assert property (
        @(posedge clock) disable iff (!nrst)
        read && waitrequest |=> readdata[31:8] == 24'h000000)
        else $error("read data upper bytes not zero");
    a_unmapped_read: assert property (
        @(posedge clock) disable iff (!nrst)
        read && waitrequest && !hit |=> readdata == 32'h00000000)
        else $error("unmapped read not zero");

    a_frame_capture: assert property (
        @(posedge clock) disable iff (!nrst)
        sof_done && sof_frame <= usb_cfg_pkg::frame_max
        |=> st_ff.frame == $past(sof_frame))
        else $error("frame count not captured");
    a_frame_low_read: assert property (
        @(posedge clock) disable iff (!nrst)
        read && waitrequest && idx == usb_cfg_pkg::idx_frame_low
        |=> readdata[7:0] == $past(st_ff.frame[7:0]))
        else $error("frame count low byte misread");
    a_frame_high_read: assert property (
        @(posedge clock) disable iff (!nrst)
        read && waitrequest && idx == usb_cfg_pkg::idx_frame_high
        |=> readdata[7:0] == {5'h00, $past(st_ff.frame[10:8])})
        else $error("frame count high byte misread");
    a_frame_overflow: assert property (
        @(posedge clock) disable iff (!nrst)
        sof_done && sof_frame > usb_cfg_pkg::frame_max
        |=> st_ff.frame == usb_cfg_pkg::frame_zero)
        else $error("frame count beyond range not zeroed");
    a_frame_wrap: assert property (
        @(posedge clock) disable iff (!nrst)
        st_ff.frame <= usb_cfg_pkg::frame_max)
        else $error("frame count beyond 3ff");
    a_frame_hold: assert property (
        @(posedge clock) disable iff (!nrst)
        !sof_done |=> st_ff.frame == $past(st_ff.frame))
        else $error("frame count changed without SOF");

    a_addr_capture: assert property (
        @(posedge clock) disable iff (!nrst)
        addr_load |=> st_ff.dev_addr == $past(addr_value))
        else $error("device address not captured");
    a_addr_hold: assert property (
        @(posedge clock) disable iff (!nrst)
        !addr_load |=> st_ff.dev_addr == $past(st_ff.dev_addr))
        else $error("device address changed without load");
    a_addr_read: assert property (
        @(posedge clock) disable iff (!nrst)
        read && waitrequest && idx == usb_cfg_pkg::idx_dev_addr
        |=> readdata[7:0] == {1'b0, $past(st_ff.dev_addr)})
        else $error("device address misread");
    a_addr_filter: assert property (
        @(posedge clock) disable iff (!nrst)
        token.valid && token.addr != st_ff.dev_addr && !addr_load
        |=> !reply.respond)
        else $error("foreign address answered");
    a_addr_match: assert property (
        @(posedge clock) disable iff (!nrst)
        reply.respond
        |-> $past(token.valid) &&
            $past(token.addr) == $past(st_ff.dev_addr))
        else $error("reply without matching address");

    a_iso_zlp: assert property (
        @(posedge clock) disable iff (!nrst)
        reply.zero_len |-> cfg.pairing[usb_cfg_pkg::zlp_bit])
        else $error("zero-length sent with option off");
    a_zlp_respond: assert property (
        @(posedge clock) disable iff (!nrst)
        reply.zero_len |-> reply.respond)
        else $error("zero-length flag without reply");
    a_zlp_empty: assert property (
        @(posedge clock) disable iff (!nrst)
        reply.zero_len
        |-> $past(token.buf_empty) &&
            $past(token.endp) == usb_cfg_pkg::iso_ep &&
            $past(token.kind) == usb_cfg_pkg::pid_in)
        else $error("zero-length outside empty iso IN");
    a_iso_silent: assert property (
        @(posedge clock) disable iff (!nrst)
        token.valid && token.buf_empty &&
        token.endp == usb_cfg_pkg::iso_ep &&
        token.kind == usb_cfg_pkg::pid_in &&
        !cfg.pairing[usb_cfg_pkg::zlp_bit]
        |=> !reply.respond)
        else $error("empty iso IN answered with option off");

    a_pair_upper: assert property (
        @(posedge clock) disable iff (!nrst)
        cfg.pairing[6:5] == 2'h0)
        else $error("unused pairing bits set");
    a_pair_write: assert property (
        @(posedge clock) disable iff (!nrst)
        write && !waitrequest && byteenable[0] &&
        idx == usb_cfg_pkg::idx_pairing
        |=> cfg.pairing ==
            ($past(writedata[7:0]) & usb_cfg_pkg::pair_mask))
        else $error("pairing write not stored");

    a_bulk_in_fixed: assert property (
        @(posedge clock) disable iff (!nrst)
        cfg.bulk_in[0] && cfg.bulk_in[7:6] == 2'h0)
        else $error("fixed IN active bits wrong");
    a_bulk_out_fixed: assert property (
        @(posedge clock) disable iff (!nrst)
        cfg.bulk_out[0] && cfg.bulk_out[7:6] == 2'h0)
        else $error("fixed OUT active bits wrong");
    a_bulk_in_write: assert property (
        @(posedge clock) disable iff (!nrst)
        write && !waitrequest && byteenable[0] &&
        idx == usb_cfg_pkg::idx_bulk_in
        |=> cfg.bulk_in == (($past(writedata[7:0]) &
            usb_cfg_pkg::bulk_mask) | usb_cfg_pkg::bulk_fixed))
        else $error("IN active write not stored");
    a_bulk_out_write: assert property (
        @(posedge clock) disable iff (!nrst)
        write && !waitrequest && byteenable[0] &&
        idx == usb_cfg_pkg::idx_bulk_out
        |=> cfg.bulk_out == (($past(writedata[7:0]) &
            usb_cfg_pkg::bulk_mask) | usb_cfg_pkg::bulk_fixed))
        else $error("OUT active write not stored");
    a_bulk_in_idle: assert property (
        @(posedge clock) disable iff (!nrst)
        token.valid && token.kind == usb_cfg_pkg::pid_in &&
        !token.endp[3] && token.endp != usb_cfg_pkg::ep_zero &&
        !cfg.bulk_in[token.endp[2:0]]
        |=> !reply.respond)
        else $error("inactive IN endpoint answered");
    a_bulk_out_idle: assert property (
        @(posedge clock) disable iff (!nrst)
        token.valid && token.kind != usb_cfg_pkg::pid_in &&
        !token.endp[3] && token.endp != usb_cfg_pkg::ep_zero &&
        !cfg.bulk_out[token.endp[2:0]]
        |=> !reply.respond)
        else $error("inactive OUT endpoint answered");

    a_iso_in_bits: assert property (
        @(posedge clock) disable iff (!nrst)
        cfg.iso_in[7:1] == 7'h00)
        else $error("iso IN active upper bits set");
    a_iso_out_bits: assert property (
        @(posedge clock) disable iff (!nrst)
        cfg.iso_out[7:1] == 7'h00)
        else $error("iso OUT active upper bits set");
    a_iso_in_idle: assert property (
        @(posedge clock) disable iff (!nrst)
        token.valid && token.endp == usb_cfg_pkg::iso_ep &&
        token.kind == usb_cfg_pkg::pid_in && !cfg.iso_in[0]
        |=> !reply.respond)
        else $error("inactive iso IN answered");
    a_iso_out_idle: assert property (
        @(posedge clock) disable iff (!nrst)
        token.valid && token.endp == usb_cfg_pkg::iso_ep &&
        token.kind != usb_cfg_pkg::pid_in && !cfg.iso_out[0]
        |=> !reply.respond)
        else $error("inactive iso OUT answered");

    a_setup_capture: assert property (
        @(posedge clock) disable iff (!nrst)
        setup_done |=> st_ff.setup == $past(setup_data))
        else $error("setup bytes not captured");
    a_setup_read: assert property (
        @(posedge clock) disable iff (!nrst)
        read && waitrequest &&
        idx[15:3] == usb_cfg_pkg::idx_setup_base[15:3]
        |=> readdata[7:0] == $past(st_ff.setup[idx[2:0]*8 +: 8]))
        else $error("setup byte misread");
    a_setup_hold: assert property (
        @(posedge clock) disable iff (!nrst)
        !setup_done |=> st_ff.setup == $past(st_ff.setup))
        else $error("setup buffer changed mid packet");

    a_rx_base_low: assert property (
        @(posedge clock) disable iff (!nrst)
        cfg.iso_rx_base[1:0] == 2'h0)
        else $error("iso OUT base low bits set");
    a_tx_base_low: assert property (
        @(posedge clock) disable iff (!nrst)
        cfg.iso_tx_base[1:0] == 2'h0)
        else $error("iso IN base low bits set");
    a_rx_base_write: assert property (
        @(posedge clock) disable iff (!nrst)
        write && !waitrequest && byteenable[0] &&
        idx == usb_cfg_pkg::idx_iso_rx_base
        |=> cfg.iso_rx_base ==
            ($past(writedata[7:0]) & usb_cfg_pkg::base_mask))
        else $error("iso OUT base write not stored");
    a_tx_base_write: assert property (
        @(posedge clock) disable iff (!nrst)
        write && !waitrequest && byteenable[0] &&
        idx == usb_cfg_pkg::idx_iso_tx_base
        |=> cfg.iso_tx_base ==
            ($past(writedata[7:0]) & usb_cfg_pkg::base_mask))
        else $error("iso IN base write not stored");
endmodule

// ### usb_cfg_pkg.sv
package usb_cfg_pkg;
    // Register indices (printed offsets; byte address is index * 4)
    localparam logic [15:0] idx_frame_low = 16'hc7d8;
    localparam logic [15:0] idx_frame_high = 16'hc7d9;
    localparam logic [15:0] idx_dev_addr = 16'hc7db;
    localparam logic [15:0] idx_pairing = 16'hc7dd;
    localparam logic [15:0] idx_bulk_in = 16'hc7de;
    localparam logic [15:0] idx_bulk_out = 16'hc7df;
    localparam logic [15:0] idx_iso_in = 16'hc7e0;
    localparam logic [15:0] idx_iso_out = 16'hc7e1;
    localparam logic [15:0] idx_setup_base = 16'hc7e8;
    localparam logic [15:0] idx_iso_rx_base = 16'hc7f0;
    localparam logic [15:0] idx_iso_tx_base = 16'hc7f8;

    localparam int frame_w = 11;
    localparam logic [10:0] frame_max = 11'h3ff;
    localparam logic [10:0] frame_zero = 11'h000;
    localparam int zlp_bit = 7;
    localparam int pair_rx45_bit = 4;
    localparam int pair_rx23_bit = 3;
    localparam int pair_tx67_bit = 2;
    localparam int pair_tx45_bit = 1;
    localparam int pair_tx23_bit = 0;
    localparam logic [7:0] pair_mask = 8'h9f;
    localparam logic [7:0] bulk_mask = 8'h3e;
    localparam logic [7:0] bulk_fixed = 8'h01;
    localparam logic [7:0] iso_act_mask = 8'h01;
    localparam logic [7:0] base_mask = 8'hfc;
    localparam logic [7:0] reg_reset = 8'h00;
    localparam logic [6:0] addr_none = 7'h00;
    localparam logic [3:0] iso_ep = 4'h8;
    localparam logic [3:0] ep_zero = 4'h0;

    typedef enum logic [1:0] {
        pid_out = 2'h0,
        pid_in = 2'h1,
        pid_setup = 2'h2
    } token_kind_t;

    typedef struct packed {
        logic valid;
        token_kind_t kind;
        logic [6:0] addr;
        logic [3:0] endp;
        logic buf_empty;
    } token_t;

    typedef struct packed {
        logic respond;
        logic zero_len;
    } reply_t;

    typedef struct packed {
        logic [7:0] pairing;
        logic [7:0] bulk_in;
        logic [7:0] bulk_out;
        logic [7:0] iso_in;
        logic [7:0] iso_out;
        logic [7:0] iso_rx_base;
        logic [7:0] iso_tx_base;
    } cfg_t;
endpackage

// ### usb_host_model.sv
module usb_host_model (
    // Clock
    input wire logic clock,
    // Packet capture strobes
    output logic sof_done,
    output logic [10:0] sof_frame,
    output logic setup_done,
    output logic [63:0] setup_data,
    output logic addr_load,
    output logic [6:0] addr_value,
    // Tokens
    output usb_cfg_pkg::token_t token
);
    initial begin
        {sof_done, sof_frame, setup_done, setup_data} = '0;
        {addr_load, addr_value, token} = '0;
    end
    // Kind 0 SOF, 1 SETUP, 2 address, 3 token; data inverts once done
    task automatic pkt(input int k, input logic [63:0] d);
        @(posedge clock);
        sof_done <= (k == 0);
        setup_done <= (k == 1);
        addr_load <= (k == 2);
        sof_frame <= d[10:0];
        setup_data <= d;
        addr_value <= d[6:0];
        token <= usb_cfg_pkg::token_t'({k == 3, d[13:0]});
        @(posedge clock);
        {sof_done, setup_done, addr_load} <= 3'h0;
        sof_frame <= ~d[10:0];
        setup_data <= ~d;
        addr_value <= ~d[6:0];
        token <= usb_cfg_pkg::token_t'({1'b0, ~d[13:0]});
    endtask
endmodule

// ### test_usb_device_endpoint_config.sv
module test_usb_device_endpoint_config;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, nrst, read, write, waitrequest;
    logic sof_done, setup_done, addr_load;
    logic [17:0] address;
    logic [31:0] writedata, readdata;
    logic [3:0] byteenable;
    logic [10:0] sof_frame;
    logic [63:0] setup_data;
    logic [6:0] addr_value;
    logic [7:0] rd;
    usb_cfg_pkg::token_t token;
    usb_cfg_pkg::reply_t reply;
    usb_cfg_pkg::cfg_t cfg;
    int miscompares = 0;
    int checks = 0;

    usb_endpoint_config DUT (.clock, .nrst, .address, .read, .write,
        .writedata, .byteenable, .readdata, .waitrequest, .sof_done,
        .sof_frame, .setup_done, .setup_data, .addr_load, .addr_value,
        .token, .reply, .cfg);
    usb_host_model host (.clock, .sof_done, .sof_frame, .setup_done,
        .setup_data, .addr_load, .addr_value, .token);

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task automatic summarize();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string n, input logic [7:0] e, logic [7:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    // Request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, logic [15:0] idx, logic [7:0] wd);
        int n;
        n = 0;
        @(posedge clock);
        address <= {idx, 2'b00};
        read <= ~wr;
        write <= wr;
        writedata <= {24'h0, wd};
        do begin
            @(posedge clock);
            n++;
            if (n > 20) begin
                miscompares++;
                summarize();
            end
        end while (waitrequest !== 1'b0);
        rd = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic rchk(input string n, logic [15:0] idx, logic [7:0] e);
        bus(1'b0, idx, 8'h00);
        chk(n, e, rd);
    endtask

    task automatic wrchk(input string n, logic [15:0] idx,
                         logic [7:0] wd, logic [7:0] e);
        bus(1'b1, idx, wd);
        rchk(n, idx, e);
    endtask

    // Token with empty buffer; reply lands one cycle later
    task automatic tok(input logic [1:0] k, logic [6:0] a, logic [3:0] ep,
                       logic [1:0] e);
        host.pkt(3, {50'h0, k, a, ep, 1'b1});
        #1;
        chk("reply", {6'h0, e}, {6'h0, reply});
    endtask

    task automatic t_regs();
        rchk("bulk_in", usb_cfg_pkg::idx_bulk_in, 8'h01);
        rchk("bulk_out", usb_cfg_pkg::idx_bulk_out, 8'h01);
        wrchk("pair", usb_cfg_pkg::idx_pairing, 8'hff, 8'h9f);
        wrchk("bulk_in", usb_cfg_pkg::idx_bulk_in, 8'hfc, 8'h3d);
        wrchk("bulk_out", usb_cfg_pkg::idx_bulk_out, 8'hc2, 8'h03);
        wrchk("iso_in", usb_cfg_pkg::idx_iso_in, 8'hff, 8'h01);
        wrchk("iso_out", usb_cfg_pkg::idx_iso_out, 8'hfe, 8'h00);
        wrchk("rx_base", usb_cfg_pkg::idx_iso_rx_base, 8'hff, 8'hfc);
        wrchk("tx_base", usb_cfg_pkg::idx_iso_tx_base, 8'h57, 8'h54);
        wrchk("dev_addr", usb_cfg_pkg::idx_dev_addr, 8'h55, 8'h00);
        wrchk("frame_hi", usb_cfg_pkg::idx_frame_high, 8'h07, 8'h00);
        wrchk("unmapped", 16'hc7dc, 8'hff, 8'h00);
        chk("cfg_pair", 8'h9f, cfg.pairing);
        chk("cfg_bulk_in", 8'h3d, cfg.bulk_in);
        chk("cfg_bulk_out", 8'h03, cfg.bulk_out);
        chk("cfg_iso_in", 8'h01, cfg.iso_in);
        chk("cfg_iso_out", 8'h00, cfg.iso_out);
        chk("cfg_rx_base", 8'hfc, cfg.iso_rx_base);
        chk("cfg_tx_base", 8'h54, cfg.iso_tx_base);
    endtask

    task automatic t_tokens();
        tok(2'h1, 7'h00, 4'h1, 2'b00);
        tok(2'h1, 7'h00, 4'h2, 2'b10);
        tok(2'h0, 7'h00, 4'h2, 2'b00);
        tok(2'h0, 7'h00, 4'h1, 2'b10);
        tok(2'h1, 7'h00, 4'h8, 2'b11);
        tok(2'h0, 7'h00, 4'h8, 2'b00);
        wrchk("pair", usb_cfg_pkg::idx_pairing, 8'h1f, 8'h1f);
        tok(2'h1, 7'h00, 4'h8, 2'b00);
        host.pkt(2, 64'h7f);
        rchk("dev_addr", usb_cfg_pkg::idx_dev_addr, 8'h7f);
        tok(2'h1, 7'h7f, 4'h2, 2'b10);
        tok(2'h1, 7'h00, 4'h2, 2'b00);
        tok(2'h2, 7'h7f, 4'h0, 2'b10);
    endtask

    task automatic t_capture();
        host.pkt(0, 64'h3fe);
        rchk("frame_lo", usb_cfg_pkg::idx_frame_low, 8'hfe);
        rchk("frame_hi", usb_cfg_pkg::idx_frame_high, 8'h03);
        host.pkt(0, 64'h3ff);
        rchk("frame_lo", usb_cfg_pkg::idx_frame_low, 8'hff);
        host.pkt(0, 64'h000);
        rchk("frame_lo", usb_cfg_pkg::idx_frame_low, 8'h00);
        rchk("frame_hi", usb_cfg_pkg::idx_frame_high, 8'h00);
        host.pkt(1, 64'h8877665544332211);
        for (int k = 0; k < 8; k++)
            rchk("setup", usb_cfg_pkg::idx_setup_base + 16'(k),
                 8'(8'h11 * (k + 1)));
    endtask

    initial begin
        nrst = 1'b0;
        {read, write} = 2'b00;
        address = '0;
        writedata = '0;
        byteenable = 4'hf;
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        t_regs();
        t_tokens();
        t_capture();
        summarize();
    end
endmodule
